// File: regen_repeater.sv
// Purpose: one regenerative telegraph repeater channel with auto mode
// Assumes: line_in, ext_tick and bus strobes synchronous to clk_sys
// Notes:   CTRL[1:0] rate, [2] external timing, [3] manual, [4] manual s/s
//          CFG[1:0] code level 5..8, [2] mark hold, [3] high noise threshold
`timescale 1ns/1ns

// Functional notes
// - external timing: divide external oscillator by 256 per bit
// - four internal oscillator rates, one per rate setting
// - synchronous phase correction moves timing one 128th of a bit
// - synchronisation logic runs on a 128x bit-rate timing tick
// - auto mode: Mark held one second or longer selects start-stop
// - auto mode: start-stop pattern within 50 characters selects start-stop
// - auto mode: characters at the selected start-stop rate select start-stop
// - auto mode: missing Mark rest between characters selects synchronous
// - manual mode: ignore detection, use the manual mode select input
// - mark hold: force Mark over the whole stop interval
// - Space pulse of half a bit or less never starts a character
// - tolerate 45 percent marking or spacing distortion
// - output transitions within one percent of a bit of ideal
// - static setting picks one of two noise switching thresholds
// - lost synchronous signal inhibits output to steady Mark
// - start-stop codes of 5, 6, 7 or 8 data levels
module regen_repeater
#(
  parameter int unsigned LONG_MARK = 32'(rgn_pkg::LONG_MARK_CYC)
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        line_in,
  input  wire logic        ext_tick,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output      logic [7:0]  rd_data,
  output      logic        line_out,
  output      logic        ss_mode,
  output      logic        sync_lost
);
  import rgn_pkg::*;

  // ****************************************
  // rate constants
  // ****************************************
  localparam logic [NCO_W-1:0] INC_S0 = nco_inc(SYN_CB0);
  localparam logic [NCO_W-1:0] INC_S1 = nco_inc(SYN_CB1);
  localparam logic [NCO_W-1:0] INC_S2 = nco_inc(SYN_CB2);
  localparam logic [NCO_W-1:0] INC_S3 = nco_inc(SYN_CB3);
  localparam logic [NCO_W-1:0] INC_A0 = nco_inc(SS_CB0);
  localparam logic [NCO_W-1:0] INC_A1 = nco_inc(SS_CB1);
  localparam logic [NCO_W-1:0] INC_A2 = nco_inc(SS_CB2);
  localparam logic [NCO_W-1:0] INC_A3 = nco_inc(SS_CB3);
  localparam logic [23:0] LONG_MARK_W = LONG_MARK[23:0];

  state_s st_r;
  state_s st_nxt;

  logic [NCO_W-1:0] inc_s;
  logic [NCO_W-1:0] inc_a;
  logic             tick_s;
  logic             tick_a;
  logic [7:0]       ph_sum;
  logic             wrap;
  logic [3:0]       nbits;
  logic [3:0]       hit_thr;
  logic             fr_valid;
  logic             fr_miss;
  logic             mark_hold;
  logic             manual;
  logic             ext_on;

  always_comb
  begin
    unique case (st_r.ctrl[1:0])
      2'h0:
      begin
        inc_s = INC_S0;
        inc_a = INC_A0;
      end
      2'h1:
      begin
        inc_s = INC_S1;
        inc_a = INC_A1;
      end
      2'h2:
      begin
        inc_s = INC_S2;
        inc_a = INC_A2;
      end
      2'h3:
      begin
        inc_s = INC_S3;
        inc_a = INC_A3;
      end
    endcase
  end

  assign ext_on    = st_r.ctrl[2];
  assign manual    = st_r.ctrl[3];
  assign mark_hold = st_r.cfg[2];
  assign nbits     = 4'h5 + {2'h0, st_r.cfg[1:0]};
  assign hit_thr   = st_r.cfg[3] ? HITS_HI : HITS_LO;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt   = st_r;
    tick_s   = 1'b0;
    tick_a   = 1'b0;
    ph_sum   = 8'h00;
    wrap     = 1'b0;
    fr_valid = 1'b0;
    fr_miss  = 1'b0;

    // 128x ticks: NCO stands in for the oscillator divider chain
    st_nxt.nco_s = {1'b0, st_r.nco_s[NCO_W-1:0]} + {1'b0, inc_s};
    st_nxt.nco_a = {1'b0, st_r.nco_a[NCO_W-1:0]} + {1'b0, inc_a};
    if (ext_on)
    begin
      // 256x external clock halved gives the 128x tick
      if (ext_tick)
        st_nxt.ext_half = ~st_r.ext_half;
      tick_s = ext_tick & st_r.ext_half;
      tick_a = tick_s;
    end
    else
    begin
      tick_s = st_r.nco_s[NCO_W];
      tick_a = st_r.nco_a[NCO_W];
    end

    // ****************************************
    // synchronous bit timing
    // ****************************************
    st_nxt.prev_in = line_in;
    if (line_in != st_r.prev_in)
    begin
      st_nxt.edge_pend = 1'b1;
      st_nxt.edge_ph   = st_r.phase;
    end
    if (tick_s)
    begin
      // one step early or late per tick, never a jump
      ph_sum = {1'b0, st_r.phase} + 8'h01;
      if (st_r.edge_pend && st_r.edge_ph != 7'h00)
      begin
        if (st_r.edge_ph < PH_CENTRE)
          ph_sum = {1'b0, st_r.phase};
        else
          ph_sum = {1'b0, st_r.phase} + 8'h02;
      end
      if (st_r.edge_pend)
      begin
        st_nxt.edge_pend   = (line_in != st_r.prev_in);
        st_nxt.edge_in_bit = 1'b1;
      end
      st_nxt.phase = ph_sum[6:0];
      wrap = ph_sum[7];
      if (st_r.phase == PH_CENTRE)
        st_nxt.sync_bit = line_in;
    end

    if (wrap)
    begin
      // phase keeps running with no input, so reconnection is in step
      st_nxt.edge_in_bit = 1'b0;
      if (st_r.edge_in_bit)
      begin
        st_nxt.quiet_bits = 8'h00;
        st_nxt.sync_lost  = 1'b0;
      end
      else if (st_r.quiet_bits == LOSS_BITS)
        st_nxt.sync_lost = 1'b1;
      else
        st_nxt.quiet_bits = st_r.quiet_bits + 8'h01;
      if (!st_r.ss_mode)
        st_nxt.out = st_nxt.sync_lost ? 1'b1 : st_r.sync_bit;
      // character window at synchronous cadence
      if (st_r.win_bits == nbits + 4'h1)
      begin
        st_nxt.win_bits = 4'h0;
        if (st_r.win_chars == 6'(WIN_CHARS - 1))
        begin
          st_nxt.win_chars = 6'h00;
          st_nxt.hits      = 4'h0;
        end
        else
          st_nxt.win_chars = st_r.win_chars + 6'h01;
      end
      else
        st_nxt.win_bits = st_r.win_bits + 4'h1;
    end

    // ****************************************
    // start-stop framer
    // ****************************************
    if (tick_a)
    begin
      unique case (st_r.fr)
        FR_IDLE:
        begin
          if (!line_in)
          begin
            st_nxt.fr     = FR_START;
            st_nxt.fr_cnt = 7'h00;
          end
        end
        FR_START:
        begin
          st_nxt.fr_cnt = st_r.fr_cnt + 7'h01;
          if (line_in)
            st_nxt.fr = FR_IDLE;
          else if (st_r.fr_cnt == PH_CENTRE)
          begin
            st_nxt.fr      = FR_DATA;
            st_nxt.fr_cnt  = 7'h00;
            st_nxt.fr_bits = 4'h0;
            if (st_r.ss_mode)
              st_nxt.out = 1'b0;
          end
        end
        FR_DATA:
        begin
          st_nxt.fr_cnt = st_r.fr_cnt + 7'h01;
          if (st_r.fr_cnt == PH_LAST)
          begin
            st_nxt.fr_bits = st_r.fr_bits + 4'h1;
            if (st_r.ss_mode)
              st_nxt.out = line_in;
            if (st_r.fr_bits == nbits - 4'h1)
              st_nxt.fr = FR_STOP;
          end
        end
        FR_STOP:
        begin
          // last data element must stand a full bit, so no Mark before the stop sample
          st_nxt.fr_cnt = st_r.fr_cnt + 7'h01;
          if (st_r.fr_cnt == PH_LAST)
          begin
            st_nxt.fr = FR_IDLE;
            fr_valid  = line_in;
            fr_miss   = ~line_in;
            if (st_r.ss_mode)
              st_nxt.out = mark_hold ? 1'b1 : line_in;
          end
        end
      endcase
    end

    // ****************************************
    // mode detection
    // ****************************************
    if (!line_in)
      st_nxt.mark_cnt = 24'h000000;
    else if (st_r.mark_cnt != LONG_MARK_W)
      st_nxt.mark_cnt = st_r.mark_cnt + 24'h000001;

    if (fr_valid)
    begin
      st_nxt.miss = 3'h0;
      if (st_r.consec != 2'h3)
        st_nxt.consec = st_r.consec + 2'h1;
      if (st_r.hits != 4'hF)
        st_nxt.hits = st_r.hits + 4'h1;
    end
    if (fr_miss)
    begin
      st_nxt.consec = 2'h0;
      if (st_r.miss != MISS_LIMIT)
        st_nxt.miss = st_r.miss + 3'h1;
    end

    if (!st_r.ss_mode)
    begin
      // any one condition is enough
      if (st_r.mark_cnt == LONG_MARK_W
          || st_r.hits >= hit_thr
          || st_r.consec >= 2'h2)
      begin
        st_nxt.pend_v  = 1'b1;
        st_nxt.pend_ss = 1'b1;
      end
    end
    else if (st_r.miss == MISS_LIMIT)
    begin
      st_nxt.pend_v  = 1'b1;
      st_nxt.pend_ss = 1'b0;
    end

    // automatic switch only between characters and on a bit boundary; the manual switch below acts at once
    if (st_r.pend_v && wrap && st_r.fr == FR_IDLE)
    begin
      st_nxt.ss_mode = st_r.pend_ss;
      st_nxt.pend_v  = 1'b0;
      st_nxt.hits    = 4'h0;
      st_nxt.consec  = 2'h0;
      st_nxt.miss    = 3'h0;
      st_nxt.out     = 1'b1;
    end

    if (manual)
    begin
      st_nxt.pend_v = 1'b0;
      if (st_r.ss_mode != st_r.ctrl[4])
      begin
        st_nxt.ss_mode = st_r.ctrl[4];
        st_nxt.out     = 1'b1;
      end
    end

    // ****************************************
    // register port
    // ****************************************
    st_nxt.rd_data = 8'h00;
    if (wr)
    begin
      unique case (addr)
        ADDR_CTRL: st_nxt.ctrl = wdata;
        ADDR_CFG:  st_nxt.cfg  = {4'h0, wdata[3:0]};
        default:   st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    if (rd)
    begin
      unique case (addr)
        ADDR_CTRL:   st_nxt.rd_data = st_r.ctrl;
        ADDR_CFG:    st_nxt.rd_data = st_r.cfg;
        ADDR_STATUS: st_nxt.rd_data = {4'h0, line_in, st_r.pend_v,
                                       st_r.sync_lost, st_r.ss_mode};
        default:     st_nxt.rd_data = 8'h00;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r          <= '0;
      st_r.fr       <= FR_IDLE;
      st_r.prev_in  <= 1'b1;
      st_r.out      <= 1'b1;
      st_r.ctrl     <= CTRL_RST;
      st_r.cfg      <= CFG_RST;
    end
    else if (ce)
      st_r <= st_nxt;
  end

  assign rd_data   = st_r.rd_data;
  assign line_out  = st_r.out;
  assign ss_mode   = st_r.ss_mode;
  assign sync_lost = st_r.sync_lost;

endmodule : regen_repeater

// File: rgn_pkg.sv
// Purpose: constants and types for the regenerative repeater channel
// Assumes: 10 MHz system clock, line Mark = 1, Space = 0
// Notes:   rates held in centi-baud so fractional rates stay exact
package rgn_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam longint CLK_HZ        = 10_000_000;
  localparam int     CLK_PERIOD_NS = 100;
  localparam int     NCO_W         = 24;
  localparam int     OVS           = 128;
  localparam int     EXT_DIV       = 256;
  localparam logic [6:0] PH_CENTRE = 7'h40;
  localparam logic [6:0] PH_LAST   = 7'h7F;
  localparam int     LONG_MARK_S   = 1;
  localparam longint LONG_MARK_CYC = LONG_MARK_S * CLK_HZ;
  localparam int     WIN_CHARS     = 50;
  localparam logic [3:0] HITS_LO   = 4'h2;
  localparam logic [3:0] HITS_HI   = 4'h5;
  localparam logic [2:0] MISS_LIMIT = 3'h3;
  localparam logic [7:0] LOSS_BITS = 8'h40;

  // internal oscillator per rate setting, hertz
  localparam longint OSC_HZ0 = 76_800;
  localparam longint OSC_HZ1 = 93_237;
  localparam longint OSC_HZ2 = 125_217;
  localparam longint OSC_HZ3 = 152_016;
  // synchronous and start-stop rate of each setting, centi-baud
  localparam longint SYN_CB0 = 3750;
  localparam longint SYN_CB1 = 6110;
  localparam longint SYN_CB2 = 7500;
  localparam longint SYN_CB3 = 15000;
  localparam longint SS_CB0  = 4550;
  localparam longint SS_CB1  = 7420;
  localparam longint SS_CB2  = 7500;
  localparam longint SS_CB3  = 15000;

  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CFG    = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] CFG_RST     = 8'h00;

  function automatic logic [NCO_W-1:0] nco_inc(input longint cbaud);
    longint v;
    v = (cbaud * OVS * (longint'(1) << NCO_W)) / (100 * CLK_HZ);
    return v[NCO_W-1:0];
  endfunction : nco_inc

  typedef enum logic [3:0] {
    FR_IDLE  = 4'h1,
    FR_START = 4'h2,
    FR_DATA  = 4'h4,
    FR_STOP  = 4'h8
  } frame_e;

  typedef struct packed {
    logic [7:0] addr_unused;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic [NCO_W:0] nco_s;
    logic [NCO_W:0] nco_a;
    logic           ext_half;
    logic [6:0]     phase;
    logic           prev_in;
    logic           edge_pend;
    logic [6:0]     edge_ph;
    logic           edge_in_bit;
    logic [7:0]     quiet_bits;
    logic           sync_lost;
    logic           sync_bit;
    frame_e         fr;
    logic [6:0]     fr_cnt;
    logic [3:0]     fr_bits;
    logic [2:0]     miss;
    logic [3:0]     hits;
    logic [1:0]     consec;
    logic [5:0]     win_chars;
    logic [3:0]     win_bits;
    logic [23:0]    mark_cnt;
    logic           ss_mode;
    logic           pend_v;
    logic           pend_ss;
    logic           out;
    logic [7:0]     ctrl;
    logic [7:0]     cfg;
    logic [7:0]     rd_data;
  } state_s;

endpackage : rgn_pkg

// File: line_src.sv
// Purpose: sending telegraph loop feeding the repeater input
// Assumes: one bit lasts BIT system clocks, Mark = 1
// Notes:   line starts at Mark; after send it holds the last element sent; a loop cannot float
`timescale 1ns/1ns
module line_src #(
  parameter int BIT = 256
)(
  input  wire logic clk_sys,
  output      logic line
);
  initial line = 1'b1;

  // element order lsb first, caller places start and stop
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      line <= v[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask : send

  task automatic idle(input int cyc);
    line <= 1'b1;
    repeat (cyc) @(posedge clk_sys);
  endtask : idle

  // short Space burst, as line noise would make
  task automatic pulse(input int cyc);
    line <= 1'b0;
    repeat (cyc) @(posedge clk_sys);
    line <= 1'b1;
  endtask : pulse
endmodule : line_src

// File: regen_repeater_props.sv
// Purpose: port-level checks of the repeater channel
// Assumes: external timing ticks every clock while CTRL[2] is set
// Notes:   CTRL is shadowed from bus writes, never read back
`timescale 1ns/1ns
module regen_repeater_props
  import rgn_pkg::*;
#(
  parameter int unsigned LONG_MARK = 32'd2000
)(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       ce,
  input wire logic       line_in,
  input wire logic       ext_tick,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rd_data,
  input wire logic       line_out,
  input wire logic       ss_mode,
  input wire logic       sync_lost
);
  logic [7:0]  ctrl_sh;
  logic [31:0] mark_run;
  logic [31:0] sp_run;
  logic [31:0] in_run;
  logic        lin_q;

  // ****************************************
  // helper counters
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_sh  <= 8'h00;
      mark_run <= 32'h0;
      sp_run   <= 32'h0;
      in_run   <= 32'h0;
      lin_q    <= 1'b1;
    end
    else if (ce)
    begin
      if (wr && addr == ADDR_CTRL)
        ctrl_sh <= wdata;
      mark_run <= line_in ? mark_run + 32'h1 : 32'h0;
      sp_run   <= line_out ? 32'h0 : sp_run + 32'h1;
      in_run   <= (line_in == lin_q) ? in_run + 32'h1 : 32'h0;
      lin_q    <= line_in;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // assertions
  // ****************************************
  a_rd_quiet: assert property (!rd |=> rd_data == 8'h00)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (rd && addr > ADDR_STATUS |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_upper: assert property (rd && addr == ADDR_CFG |=> rd_data[7:4] == 4'h0)
    else $error("cfg upper bits not zero");
  a_manual_hold: assert property (ctrl_sh[3] && $stable(ctrl_sh) |-> ss_mode == ctrl_sh[4])
    else $error("manual mode not followed");
  a_long_mark: assert property (!ctrl_sh[3] && ctrl_sh[2] &&
      mark_run == LONG_MARK + 32'd600 |-> ss_mode)
    else $error("long mark did not select start-stop");
  a_space_len: assert property (ss_mode && $past(ss_mode) && $past(ss_mode, 2) && ctrl_sh[2]
      && $rose(line_out) |-> (sp_run[7:0] + 8'h01) <= 8'h02)
    else $error("space run not whole bits");
  a_mode_chg_mark: assert property (!ctrl_sh[3] && $changed(ss_mode) |-> ##[0:1] line_out)
    else $error("mode change not at Mark");
  a_lost_mark: assert property (sync_lost && $past(sync_lost) && !ss_mode |-> line_out)
    else $error("lost signal not held at Mark");
  a_lost_quiet: assert property ($rose(sync_lost) && ctrl_sh[2] |-> in_run >= 32'd16000)
    else $error("signal lost flagged too early");
endmodule : regen_repeater_props

bind regen_repeater regen_repeater_props #(.LONG_MARK(LONG_MARK)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .line_in(line_in), .ext_tick(ext_tick),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rd_data(rd_data),
  .line_out(line_out), .ss_mode(ss_mode), .sync_lost(sync_lost)
);

// File: testbench.sv
// Purpose: self-checking bench for the repeater channel
// Assumes: external timing tick every clock, so one bit is 256 clocks
// Notes:   short long-mark count keeps the run small
`timescale 1ns/1ns
module testbench;
  import rgn_pkg::*;
  localparam int BIT = 256;
  logic       clk_sys, rst_b, ce, line_in, ext_tick, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, rd_data;
  logic       line_out, ss_mode, sync_lost;
  int         bad_count, cmp_count;

  regen_repeater #(.LONG_MARK(2000)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .line_in(line_in), .ext_tick(ext_tick),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rd_data(rd_data),
    .line_out(line_out), .ss_mode(ss_mode), .sync_lost(sync_lost)
  );
  line_src #(.BIT(BIT)) u_src (.clk_sys(clk_sys), .line(line_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic go(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : go

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1 check(rd_data, exp);
  endtask : rd_chk

  // one character; stop element always expected at Mark on the output
  task automatic ss_char(input int n, input logic [7:0] d, input logic stop, input logic chk);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < n; i++)
      v[i+1] = d[i];
    v[n+1] = stop;
    @(posedge clk_sys);
    fork
      u_src.send(v, n + 2);
      if (chk)
        for (int k = 0; k < n + 2; k++)
        begin
          go(BIT);
          check(8'(line_out), 8'((k == n + 1) ? 1'b1 : v[k]));
        end
    join
    @(posedge clk_sys);
    u_src.idle(2 * BIT);
  endtask : ss_char

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    rd_chk(ADDR_CTRL, CTRL_RST);
    rd_chk(ADDR_CFG, CFG_RST);
    rd_chk(4'h3, 8'h00);
    rd_chk(ADDR_STATUS, 8'h08);
    wr_reg(ADDR_CFG, 8'hFF);
    rd_chk(ADDR_CFG, 8'h0F);
    wr_reg(ADDR_CFG, 8'h00);
    // clock enable low: the write strobe must be ignored
    ce <= 1'b0;
    wr_reg(ADDR_CFG, 8'h05);
    ce <= 1'b1;
    rd_chk(ADDR_CFG, 8'h00);
  endtask : t_regs

  task automatic t_auto;
    wr_reg(ADDR_CTRL, 8'h04);
    go(1700);
    check(8'(ss_mode), 8'h00);
    go(1000);
    check(8'(ss_mode), 8'h01);
    // alternating sync traffic never shows a Mark stop
    for (int i = 0; i < 3; i++)
      u_src.send(16'h5555, 16);
    u_src.idle(BIT);
    go(2);
    check(8'(ss_mode), 8'h00);
    for (int i = 0; i < 3; i++)
      ss_char(5, 8'h15 + 8'(i), 1'b1, 1'b0);
    go(BIT);
    check(8'(ss_mode), 8'h01);
  endtask : t_auto

  task automatic t_manual;
    wr_reg(ADDR_CTRL, 8'h0C);
    go(3);
    check(8'(ss_mode), 8'h00);
    // steady Space has no edges, so loss must force Mark over a Space sample
    u_src.pulse(17500);
    go(1);
    check(8'(sync_lost), 8'h01);
    check(8'(line_out), 8'h01);
    // let the framer finish the frames the long Space started
    u_src.idle(8 * BIT);
    wr_reg(ADDR_CTRL, 8'h1C);
    go(3);
    check(8'(ss_mode), 8'h01);
    @(posedge clk_sys);
    u_src.pulse(100);
    for (int i = 0; i < 6; i++)
    begin
      go(64);
      check(8'(line_out), 8'h01);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(ADDR_CFG, 8'h04 | 8'(c));
      ss_char(5 + c, 8'hA5, 1'b0, 1'b1);
    end
    wr_reg(ADDR_CFG, 8'h00);
    ss_char(5, 8'h0A, 1'b1, 1'b1);
  endtask : t_manual

  initial
  begin
    rst_b     = 1'b0;
    ce        = 1'b1;
    ext_tick  = 1'b1;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 4'h0;
    wdata     = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    go(15);
    check({5'h00, line_out, ss_mode, sync_lost}, 8'h04);
    check(rd_data, 8'h00);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_auto();
    t_manual();
    print_verdict();
  end

  // hang guard, well past the planned run yet under the cycle budget
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule : testbench
